//--- design/itc_map.vh
// Constants for the instruction trace control block.
`ifndef ITC_MAP_VH
`define ITC_MAP_VH
`define ITC_MODE_NONE 2'h0
`define ITC_MODE_FLOW 2'h1
`define ITC_MODE_ALL 2'h2
`define ITC_MODE_RSVD 2'h3
`define ITC_ST_RUN 4'h1
`define ITC_ST_FORCED 4'h2
`define ITC_ST_TRACE 4'h4
`define ITC_ST_HELD 4'h8
`endif

//--- design/itc_trace_ctrl.v
// Trace exception control of the processor exception unit.
`timescale 1ns/100ps
`include "itc_map.vh"
module itc_trace_ctrl (
   input wire sys_clk,
   input wire resetn,
   input wire trace_select_high,
   input wire trace_select_low,
   input wire insn_start,
   input wire insn_flow_change,
   input wire insn_status_write,
   input wire insn_breakpoint,
   input wire insn_illegal,
   input wire insn_done,
   input wire insn_forced_exc,
   input wire bus_fault,
   input wire forced_exc_done,
   input wire trace_exc_done,
   input wire irq_pending,
   input wire trap_entry,
   output reg trace_exc_req_q,
   output reg insn_retired_q,
   output reg irq_take_q,
   output reg supervisor_set_q,
   output reg trace_clear_q,
   output reg trace_pending_q
);
   localparam [3:0] ST_RUN = `ITC_ST_RUN;
   localparam [3:0] ST_FORCED = `ITC_ST_FORCED;
   localparam [3:0] ST_TRACE = `ITC_ST_TRACE;
   localparam [3:0] ST_HELD = `ITC_ST_HELD;
   reg [3:0] state_q;
   reg [3:0] state_d;
   reg mode_flow_q;
   reg mode_all_q;
   wire [1:0] sel;
   wire start_ok;
   wire insn_complete;
   wire flow_event;
   wire want_trace;
   wire retire_plain;
   wire retire_traced;
   wire take_ok;

   // Chooses the state that follows a completed instruction.
   function [3:0] itc_after_done;
      input traced;
      input forced;
      begin
         if (!traced) begin
            itc_after_done = ST_RUN;
         end else if (forced) begin
            itc_after_done = ST_FORCED;
         end else begin
            itc_after_done = ST_TRACE;
         end
      end
   endfunction

   assign sel = {trace_select_high, trace_select_low};

   assign start_ok = insn_start & (state_q == ST_RUN);

   // An instruction completed without a suspending fault.
   assign insn_complete = insn_done & ~bus_fault;

   assign flow_event = insn_flow_change | insn_status_write | insn_breakpoint;

   assign want_trace = ~insn_illegal & (mode_all_q | (mode_flow_q & flow_event));

   // An untraced instruction retires at once.
   assign retire_plain = ((state_q == ST_RUN) | (state_q == ST_HELD)) & insn_complete & ~want_trace;

   assign retire_traced = (state_q == ST_TRACE) & trace_exc_done;

   assign take_ok = (state_d == ST_RUN) & ~((state_q == ST_RUN) & insn_done & want_trace);

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (insn_complete) begin
               state_d = itc_after_done(want_trace, insn_forced_exc);
            end else if (bus_fault && (mode_all_q || mode_flow_q)) begin
               state_d = ST_HELD;
            end else begin
               state_d = ST_RUN;
            end
         end
         ST_HELD: begin
            if (insn_complete) begin
               state_d = itc_after_done(want_trace, insn_forced_exc);
            end else begin
               state_d = ST_HELD;
            end
         end
         ST_FORCED: begin
            if (forced_exc_done) begin
               state_d = ST_TRACE;
            end else begin
               state_d = ST_FORCED;
            end
         end
         ST_TRACE: begin
            if (trace_exc_done) begin
               state_d = ST_RUN;
            end else begin
               state_d = ST_TRACE;
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode_flow_q <= 1'b0;
      end else if (start_ok) begin
         mode_flow_q <= (sel == `ITC_MODE_FLOW);
      end else begin
         mode_flow_q <= mode_flow_q;
      end
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode_all_q <= 1'b0;
      end else if (start_ok) begin
         mode_all_q <= (sel == `ITC_MODE_ALL);
      end else begin
         mode_all_q <= mode_all_q;
      end
   end

   // The trace request stands until its processing ends.
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         trace_exc_req_q <= 1'b0;
      end else begin
         trace_exc_req_q <= (state_d == ST_TRACE);
      end
   end

   // A trace is owed or in progress, or a faulted instruction is held in a trace mode.
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         trace_pending_q <= 1'b0;
      end else begin
         trace_pending_q <= (state_d != ST_RUN);
      end
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         insn_retired_q <= 1'b0;
      end else begin
         insn_retired_q <= retire_plain | retire_traced;
      end
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         irq_take_q <= 1'b0;
      end else begin
         irq_take_q <= irq_pending & take_ok;
      end
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         supervisor_set_q <= 1'b0;
      end else begin
         supervisor_set_q <= trap_entry;
      end
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         trace_clear_q <= 1'b0;
      end else begin
         trace_clear_q <= trap_entry;
      end
   end

endmodule // itc_trace_ctrl

//--- tb/itc_trace_props.sv
// Checker for trace control.
`timescale 1ns/100ps
module itc_props (
   input wire sys_clk,
   input wire resetn,
   input wire insn_done,
   input wire insn_illegal,
   input wire bus_fault,
   input wire trace_exc_done,
   input wire trap_entry,
   input wire irq_take_q,
   input wire trace_exc_req_q,
   input wire insn_retired_q,
   input wire supervisor_set_q,
   input wire trace_clear_q,
   input wire trace_pending_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence s_end;
      trace_exc_req_q && trace_exc_done;
   endsequence
   req_hold_a: assert property (trace_exc_req_q && !trace_exc_done |=> trace_exc_req_q) else $error("hold");
   ret_pulse_a: assert property (s_end |=> insn_retired_q && !trace_exc_req_q) else $error("retire");
   req_pend_a: assert property (trace_exc_req_q |-> trace_pending_q) else $error("pend");
   irq_order_a: assert property (trace_pending_q |-> !irq_take_q) else $error("irq");
   fault_defer_a: assert property (bus_fault && !trace_exc_req_q |=> !trace_exc_req_q) else $error("fault");
   illegal_insn_a: assert property (insn_done && insn_illegal |=> !trace_exc_req_q [*2])
      else $error("illegal");
   trap_entry_a: assert property (trap_entry |=> supervisor_set_q && trace_clear_q) else $error("trap");
   reset_clear_a: assert property ($rose(resetn) |-> !trace_pending_q) else $error("reset");
endmodule // itc_props

//--- tb/itc_trace_ctrl_tb_top.sv
// Bench for trace control.
`timescale 1ns/100ps
module itc_trace_ctrl_tb_top;
   reg sys_clk = 0, resetn = 0, st = 0, dn = 0, fx = 0, te = 0, sn = 0;
   reg [1:0] m = 0;
   reg [5:0] k = 0;
   integer r = 0;
   wire q, ret, sv, tc;
   integer errors = 0, n_tests = 0, seed = 78473;
   itc_trace_ctrl u_dut (.sys_clk, .resetn, .trace_select_high(m[1]), .trace_select_low(m[0]), .insn_start(st),
      .insn_flow_change(k[0]), .insn_status_write(k[1]), .insn_breakpoint(k[2]), .insn_illegal(k[3]),
      .insn_done(dn), .insn_forced_exc(k[4]), .bus_fault(k[5]), .forced_exc_done(fx), .trace_exc_done(te),
      .irq_pending(r[0]), .trap_entry(k[4]), .trace_exc_req_q(q), .insn_retired_q(ret), .irq_take_q(),
      .supervisor_set_q(sv), .trace_clear_q(tc), .trace_pending_q());
   task chk(input a, b);
      n_tests++;
      errors += a !== b;
      if (a !== b) $display("[ERR] %0t bad", $time);
   endtask
   function exp_trace(input [1:0] d, input [5:0] e);
      exp_trace = !e[3] && !e[5] && (d == 2'h2 || d == 2'h1 && |e[2:0]);
   endfunction
   task op(input [1:0] d, input [5:0] e);
      integer nr;
      @(negedge sys_clk) {m, st, sn} = {d, 2'h2};
      @(negedge sys_clk) {m, st, dn, k} = {~d, 2'h1, e};
      @(negedge sys_clk) {dn, k, fx} = {7'h0, e[4]};
      nr = ret;
      chk(sv, e[4]);
      chk(tc, e[4]);
      repeat (4) begin
         @(negedge sys_clk) {fx, sn} = {1'h0, sn | q};
         nr = nr + ret;
      end
      chk(sn, exp_trace(d, e));
      if (sn) begin
         @(negedge sys_clk) te = 1'h1;
         nr = nr + ret;
      end
      @(negedge sys_clk) te = 1'h0;
      nr = nr + ret;
      chk(nr == 1, !e[5]);
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial forever #2.5 sys_clk = ~sys_clk;
   initial begin
      repeat (5) @(negedge sys_clk);
      resetn = 1'h1;
      op(2'h2, 6'h20);
      op(2'h2, 6'h0);
      repeat (150) begin
         r = $random(seed);
         op(r[7:6], {1'h0, r[4:1], r[0] | r[4]});
      end
      $display("run done");
      print_verdict;
   end
endmodule // itc_trace_ctrl_tb_top
bind itc_trace_ctrl itc_props u_props (.*);
